// ---- dcc_ctrl.sv ----
// Digital control and change-interrupt logic around two analog comparators.
// Assumes the analog comparators, the pins and the port latch sit outside;
// comparator results and pin levels arrive asynchronously.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Raw comparator result is high when plus input exceeds minus input.
// - Invert bit complements the reported result, for register bit and pin.
// - Three-bit mode field selects one of eight pin assignments.
// - Analog pins read back as zero whatever their level or direction.
// - Comparator-driven pins carry the comparator output instead of port data.
// - Results reach the dedicated output pins only in mode 110.
// - Adjusted results are always readable in the control register.
// - Input switch picks minus input in modes 001 (first) and 010 (both).
// - Read latch captures output on each control read, compared by XOR.
// - Sampling latch captures the output on every clock.
// - Interrupt flag is held set while a mismatch exists.
// - A control write also refreshes the read latch and ends mismatch.
// - Flag cleared only by writing 0; writing 1 sets it.
// - Interrupt needs comparator, peripheral and global enables; flag sets anyway.
// - Clearing the flag during a persistent mismatch does not last.
// - A change coinciding with a control read may not set the flag.
// - Only the second comparator feeds the timer gate and sync option.
// - Both comparators share one mode field.
// - Reset returns mode 000, inputs analog, comparators disabled.
// - Modes 000 and 111 switch both comparators off.
// - Output change wakes the device when comparator and peripheral enables set.
module dcc_ctrl
  import dcc_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port.
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  // Analog comparator side.
  input wire logic [1:0] CMP_RAW,
  output logic [1:0] CMP_EN,
  output logic [1:0] INV_SEL,
  // Pins and port latch.
  input wire logic [5:0] PIN_IN,
  input wire logic [5:0] PORT_DATA,
  output logic [5:0] PIN_OUT,
  output logic [5:0] PIN_OE_N,
  // Timer link.
  input wire logic T1_TICK,
  output logic T1_GATE,
  output logic T1_GATE_SEL,
  // Processor side.
  output logic CMP_IRQ,
  output logic WAKE
);

  dcc_state_t q;
  dcc_state_t n;
  logic cmp_on;
  logic [1:0] adj;
  logic [1:0] mism;
  logic [5:0] amask;
  logic [5:0] dmask;
  logic ctrl_acc;
  logic pir_wr;
  logic [1:0] ifl;
  logic [1:0] ien;

  // Views of the current state that several pieces of logic share.
  always_comb begin
    cmp_on = (q.mode != MODE_OFF) && (q.mode != MODE_OFF2);
    // The analog side gives high for plus above minus; off comparators give low before the invert bit.
    adj = (cmp_on ? q.cmp_s2 : 2'h0) ^ q.inv;
    mism = q.rlat ^ q.samp;
    amask = dcc_analog_mask(q.mode);
    dmask = dcc_digital_mask(q.mode);
    ctrl_acc = (RD_STB || WR_STB) && (ADDR == ADDR_CTRL);
    pir_wr = WR_STB && (ADDR == ADDR_PIR);
    ifl = q.pir[PIR_CIF_LSB+1:PIR_CIF_LSB];
    ien = q.pie[PIE_CIE_LSB+1:PIE_CIE_LSB];
  end

  // Next state: register writes, latches, flags and registered outputs.
  always_comb begin
    n = q;

    // Two-flop synchronisers; the first stage feeds only the second.
    n.cmp_s1 = CMP_RAW;
    n.cmp_s2 = q.cmp_s1;
    n.pin_s1 = PIN_IN;
    n.pin_s2 = q.pin_s1;

    // Sampling latch follows the adjusted result every clock.
    n.samp = adj;

    // Any control access, write included, reloads the read latch.
    // A change landing in that same cycle is absorbed, so no flag results.
    if (ctrl_acc) begin
      n.rlat = adj;
    end

    // Register writes.
    if (WR_STB) begin
      case (ADDR)
        ADDR_CTRL: begin
          n.mode = WR_DATA[CTRL_MODE_LSB +: 3];
          n.inv = WR_DATA[CTRL_INV_LSB +: 2];
          n.input_switch_select = WR_DATA[CTRL_CIS];
        end
        ADDR_CFG2: begin
          n.cfg2 = WR_DATA[1:0];
        end
        ADDR_GIC: begin
          n.gic = WR_DATA;
        end
        ADDR_PIE: begin
          n.pie = WR_DATA;
        end
        ADDR_PIR: begin
          n.pir = WR_DATA;
        end
        ADDR_DIR: begin
          n.dir = WR_DATA[5:0];
        end
        default: begin
          n.dir = q.dir;
        end
      endcase
    end

    // Flags: a live mismatch wins over any clear in the same cycle.
    for (int i = 0; i < 2; i++) begin
      n.pir[PIR_CIF_LSB+i] = (pir_wr ? WR_DATA[PIR_CIF_LSB+i] : q.pir[PIR_CIF_LSB+i])
                             | mism[i];
    end

    // Read data stand one cycle after the strobe and only there.
    n.rd = 8'h00;
    if (RD_STB) begin
      case (ADDR)
        ADDR_CTRL: n.rd = {adj, q.inv, q.input_switch_select, q.mode};
        ADDR_CFG2: n.rd = {6'h00, q.cfg2};
        ADDR_GIC: n.rd = q.gic;
        ADDR_PIE: n.rd = q.pie;
        ADDR_PIR: n.rd = q.pir;
        ADDR_PORT: n.rd = {2'h0, q.pin_s2 & ~amask};
        ADDR_DIR: n.rd = {2'h0, q.dir};
        default: n.rd = 8'h00;
      endcase
    end

    // Pin drive: comparator results replace port data only where routed.
    for (int p = 0; p < 6; p++) begin
      n.pout[p] = PORT_DATA[p];
    end
    if (dmask[4]) begin
      n.pout[4] = adj[0];
    end
    if (dmask[5]) begin
      n.pout[5] = adj[1];
    end
    // Software must clear direction bits itself to enable those drivers.
    n.poe_n = q.dir;

    // Analog controls.
    n.en = {2{cmp_on}};
    n.insel[0] = ((q.mode == MODE_SW1) || (q.mode == MODE_SW2)) && q.input_switch_select;
    n.insel[1] = (q.mode == MODE_SW2) && q.input_switch_select;

    // Only the second comparator reaches the timer; sync holds it between ticks.
    if (!q.cfg2[CFG2_SYNC] || T1_TICK) begin
      n.gate = adj[1];
    end

    // Interrupt and wake requests.
    n.wake = (|(ifl & ien)) && q.gic[GIC_PERIPHERAL_IRQ_ENABLE];
    n.irq = (|(ifl & ien)) && q.gic[GIC_PERIPHERAL_IRQ_ENABLE] && q.gic[GIC_GIE];
  end

  // State register; reset puts mode 000, cfg2 2'h2, dir and poe_n 6'h3F, and clears everything else.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= '0;
      q.mode <= RST_CTRL[CTRL_MODE_LSB +: 3];
      q.inv <= RST_CTRL[CTRL_INV_LSB +: 2];
      q.input_switch_select <= RST_CTRL[CTRL_CIS];
      q.cfg2 <= RST_CFG2;
      q.gic <= RST_GIC;
      q.pie <= RST_PIE;
      q.pir <= RST_PIR;
      q.dir <= RST_DIR;
      q.poe_n <= RST_DIR;
    end else begin
      q <= n;
    end
  end

  // Every output comes straight from the state register.
  assign RD_DATA = q.rd;
  assign CMP_EN = q.en;
  assign INV_SEL = q.insel;
  assign PIN_OUT = q.pout;
  assign PIN_OE_N = q.poe_n;
  assign T1_GATE = q.gate;
  assign T1_GATE_SEL = q.cfg2[CFG2_GSS];
  assign CMP_IRQ = q.irq;
  assign WAKE = q.wake;

  // Checks on the block's own behaviour.
  default clocking dcc_cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  property p_ctrl_read;
    (RD_STB && ADDR == ADDR_CTRL) |=> (RD_DATA[7:6] == $past(adj));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read lost result");

  property p_analog_zero;
    (RD_STB && ADDR == ADDR_PORT) |=> ((RD_DATA[5:0] & $past(amask)) == 6'h00);
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

  property p_pin_route;
    !RST |=> (PIN_OUT[5:4] == $past(q.mode == MODE_PINS ? adj : PORT_DATA[5:4]));
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("output pin routing wrong");

  property p_flag_held;
    mism[0] |=> q.pir[PIR_CIF_LSB];
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag not held on mismatch");

  property p_write_clears;
    (WR_STB && ADDR == ADDR_CTRL) |=> (mism == 2'h0);
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("control write kept mismatch");

  property p_soft_set;
    (pir_wr && WR_DATA[PIR_CIF_LSB+1]) |=> q.pir[PIR_CIF_LSB+1];
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("software set of flag lost");

  property p_clear_blocked;
    (pir_wr && !WR_DATA[PIR_CIF_LSB] && mism[0]) |=> q.pir[PIR_CIF_LSB];
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) else $error("flag cleared during mismatch");

  property p_irq_gate;
    CMP_IRQ |-> $past(q.gic[GIC_GIE] && q.gic[GIC_PERIPHERAL_IRQ_ENABLE] && |(ifl & ien));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enables");

  property p_off_modes;
    (q.mode == MODE_OFF || q.mode == MODE_OFF2) |=> (CMP_EN == 2'h0);
  endproperty
  a_off_modes: assert property (p_off_modes) else $error("comparator enabled when off");

  property p_reset_mode;
    $past(RST) |-> (q.mode == MODE_OFF && CMP_EN == 2'h0);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset did not force mode off");

  property p_timer_gate;
    !$past(q.cfg2[CFG2_SYNC]) |-> (T1_GATE == $past(adj[1]));
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer gate not second result");

  // Polarity, latches and synchronisers; these pin down the cycle on which each stage moves.
  property p_invert;
    (RD_STB && ADDR == ADDR_CTRL) |=> ((RD_DATA[7:6] ^ RD_DATA[5:4]) == $past(cmp_on ? q.cmp_s2 : 2'h0));
  endproperty
  a_invert: assert property (p_invert) else $error("result polarity wrong");

  property p_read_latch;
    ctrl_acc |=> (q.rlat == $past(adj));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("read latch missed access");

  property p_latch_hold;
    !ctrl_acc |=> $stable(q.rlat);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("read latch moved without access");

  property p_read_clears;
    (RD_STB && ADDR == ADDR_CTRL) |=> (mism == 2'h0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("control read kept mismatch");

  property p_sample_latch;
    !RST |=> (q.samp == $past(adj));
  endproperty
  a_sample_latch: assert property (p_sample_latch) else $error("sampling latch missed a clock");

  property p_sync_path;
    !RST |=> (q.cmp_s2 == $past(q.cmp_s1) && q.pin_s2 == $past(q.pin_s1));
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("synchroniser stage skipped");

  // Enables, switch and pin drive as functions of the one shared mode field.
  property p_enables;
    !RST |=> (CMP_EN == ($past(q.mode == MODE_OFF || q.mode == MODE_OFF2) ? 2'h0 : 2'h3));
  endproperty
  a_enables: assert property (p_enables) else $error("comparator enables wrong");

  property p_input_switch;
    !RST |=> (INV_SEL == $past((q.input_switch_select && (q.mode == MODE_SW1 || q.mode == MODE_SW2)) ?
                               {q.mode == MODE_SW2, 1'b1} : 2'h0));
  endproperty
  a_input_switch: assert property (p_input_switch) else $error("input switch select wrong");

  property p_pin_keep;
    (!RST && q.mode != MODE_PINS) |=> (PIN_OUT == $past(PORT_DATA));
  endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("port data not passed to pins");

  // Flag, wake and interrupt paths; a written 0 only clears a flag once the mismatch is gone.
  property p_wake_set;
    (q.gic[GIC_PERIPHERAL_IRQ_ENABLE] && |(ifl & ien)) |=> WAKE;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake request missing");

  property p_wake_gate;
    WAKE |-> $past(q.gic[GIC_PERIPHERAL_IRQ_ENABLE] && |(ifl & ien));
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake without enables");

  property p_irq_set;
    (q.gic[GIC_GIE] && q.gic[GIC_PERIPHERAL_IRQ_ENABLE] && |(ifl & ien)) |=> CMP_IRQ;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled interrupt missing");

  property p_flag_clear;
    (pir_wr && !WR_DATA[PIR_CIF_LSB] && !mism[0]) |=> !q.pir[PIR_CIF_LSB];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear by software lost");

  property p_flag_keep;
    (q.pir[PIR_CIF_LSB+1] && !pir_wr) |=> q.pir[PIR_CIF_LSB+1];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag dropped without a write");

  property p_second_held;
    mism[1] |=> q.pir[PIR_CIF_LSB+1];
  endproperty
  a_second_held: assert property (p_second_held) else $error("second flag not held");

  // Outputs right after reset, and the timer gate while the sync option holds it.
  property p_reset_out;
    $past(RST) |-> (PIN_OE_N == RST_DIR && RD_DATA == 8'h00 && !CMP_IRQ && !WAKE && T1_GATE_SEL);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");

  property p_gate_hold;
    (q.cfg2[CFG2_SYNC] && !T1_TICK) |=> $stable(T1_GATE);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("timer gate moved between ticks");

  // Main scenarios worth seeing.
  c_mismatch: cover property (!mism[0] ##1 mism[0]);
  c_irq: cover property ($rose(CMP_IRQ));
  c_pin_mode: cover property (q.mode == MODE_PINS && |PIN_OUT[5:4]);
  c_wake: cover property (WAKE && !CMP_IRQ);
  c_clear_blocked: cover property (pir_wr && !WR_DATA[PIR_CIF_LSB] && mism[0]);

endmodule : dcc_ctrl

`default_nettype wire

// ---- dcc_pkg.sv ----
// Shared constants for the dual comparator control block.
// Assumes an 8-bit register port with small word addresses.
package dcc_pkg;

  // Register addresses on the plain register port.
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_CFG2 = 3'h1;
  localparam logic [2:0] ADDR_GIC = 3'h2;
  localparam logic [2:0] ADDR_PIE = 3'h3;
  localparam logic [2:0] ADDR_PIR = 3'h4;
  localparam logic [2:0] ADDR_PORT = 3'h5;
  localparam logic [2:0] ADDR_DIR = 3'h6;

  // Control register fields.
  localparam int CTRL_OUT_LSB = 6;
  localparam int CTRL_INV_LSB = 4;
  localparam int CTRL_CIS = 3;
  localparam int CTRL_MODE_LSB = 0;

  // Second configuration register fields.
  localparam int CFG2_SYNC = 0;
  localparam int CFG2_GSS = 1;

  // Interrupt control fields; flag and enable of comparator n sit at LSB+n.
  localparam int GIC_GIE = 7;
  localparam int GIC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int PIE_CIE_LSB = 3;
  localparam int PIR_CIF_LSB = 3;

  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_CFG2 = 2'h2;
  localparam logic [7:0] RST_GIC = 8'h00;
  localparam logic [7:0] RST_PIE = 8'h00;
  localparam logic [7:0] RST_PIR = 8'h00;
  localparam logic [5:0] RST_DIR = 6'h3F;

  // Mode codes with special meaning.
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SW1 = 3'h1;
  localparam logic [2:0] MODE_SW2 = 3'h2;
  localparam logic [2:0] MODE_PINS = 3'h6;
  localparam logic [2:0] MODE_OFF2 = 3'h7;

  // Pins: 0 C1 plus, 1 C1 minus, 2 C2 plus, 3 C2 minus, 4 C1 out, 5 C2 out.
  function automatic logic [5:0] dcc_analog_mask(input logic [2:0] mode);
    case (mode)
      3'h5: dcc_analog_mask = 6'h0C;
      3'h7: dcc_analog_mask = 6'h00;
      default: dcc_analog_mask = 6'h0F;
    endcase
  endfunction : dcc_analog_mask

  // Pins driven by the comparators instead of the port latch.
  function automatic logic [5:0] dcc_digital_mask(input logic [2:0] mode);
    dcc_digital_mask = (mode == MODE_PINS) ? 6'h30 : 6'h00;
  endfunction : dcc_digital_mask

  // Complete state of the block.
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] inv;
    logic input_switch_select;
    logic [1:0] cfg2;
    logic [7:0] gic;
    logic [7:0] pie;
    logic [7:0] pir;
    logic [5:0] dir;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [1:0] samp;
    logic [1:0] rlat;
    logic [7:0] rd;
    logic [5:0] pout;
    logic [5:0] poe_n;
    logic irq;
    logic wake;
    logic gate;
    logic [1:0] en;
    logic [1:0] insel;
  } dcc_state_t;

endpackage : dcc_pkg

// ---- dcc_cmp_model.sv ----
// Behavioural model of the two analog comparators in front of the control block.
// Assumes the bench sets which input is higher; the result reaches the block asynchronously.
`timescale 1ns/1ns
`default_nettype none
module dcc_cmp_model (
  // Stimulus from the bench.
  input wire logic [1:0] lvl,
  input wire logic slow,
  // Block side.
  input wire logic [1:0] CMP_EN,
  output logic [1:0] CMP_RAW
);
  logic [1:0] quick;
  logic [1:0] late;
  // A comparator that is off gives a low result; the late path mimics a slow response.
  assign #7 quick = CMP_EN & lvl;
  assign #53 late = CMP_EN & lvl;
  assign CMP_RAW = slow ? late : quick;
endmodule : dcc_cmp_model
`default_nettype wire

// ---- test_dual_comparator_control_irq.sv ----
// Self-checking bench for the dual comparator control block.
// Assumes the comparator model above and the register port of the block.
`timescale 1ns/1ns
`default_nettype none
module test_dual_comparator_control_irq;
  import dcc_pkg::*;
  logic REF_CLK, RST, WR_STB, RD_STB, T1_TICK, slow, T1_GATE, T1_GATE_SEL, CMP_IRQ, WAKE;
  logic [2:0] ADDR;
  logic [7:0] WR_DATA, RD_DATA, rv;
  logic [1:0] CMP_RAW, CMP_EN, INV_SEL, lvl;
  logic [5:0] PIN_IN, PORT_DATA, PIN_OUT, PIN_OE_N;
  int bad_count, comparisons;
  dcc_cmp_model model (.lvl(lvl), .slow(slow), .CMP_EN(CMP_EN), .CMP_RAW(CMP_RAW));
  dcc_ctrl dut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RD_DATA(RD_DATA), .CMP_RAW(CMP_RAW), .CMP_EN(CMP_EN), .INV_SEL(INV_SEL),
    .PIN_IN(PIN_IN), .PORT_DATA(PORT_DATA), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
    .T1_TICK(T1_TICK), .T1_GATE(T1_GATE), .T1_GATE_SEL(T1_GATE_SEL), .CMP_IRQ(CMP_IRQ), .WAKE(WAKE));
  // Free-running 50 MHz clock.
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  // Pins that the mode hands to analog use, worked out independently of the design.
  function automatic logic [5:0] amask(input int m);
    amask = (m == 5) ? 6'h0C : (m == 7) ? 6'h00 : 6'h0F;
  endfunction : amask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : idle
  // One-cycle write strobe.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge REF_CLK);
    WR_STB <= 1'b0;
  endtask : wr
  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge REF_CLK);
    RD_STB <= 1'b0;
    #1 d = RD_DATA;
  endtask : rd
  task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rdc
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // A hang is cut short well after the tests should have ended.
  initial begin
    idle(5000);
    bad_count++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    logic [7:0] rst_tab [8];
    rst_tab = '{RST_CTRL, {6'h00, RST_CFG2}, RST_GIC, RST_PIE, RST_PIR, 8'h30, {2'h0, RST_DIR}, 8'h00};
    bad_count = 0;
    comparisons = 0;
    RST = 1'b1;
    ADDR = 3'h0;
    WR_DATA = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    T1_TICK = 1'b0;
    slow = 1'b0;
    lvl = 2'h1;
    PIN_IN = 6'h3F;
    PORT_DATA = 6'h2A;
    idle(20);
    RST <= 1'b0;
    // Reset values, the unmapped address and the one-cycle read data.
    for (int a = 0; a < 8; a++) rdc("reset reg", 3'(a), rst_tab[a]);
    @(posedge REF_CLK);
    #1 chk("read data after", 8'h00, RD_DATA);
    chk("enables", 8'h00, {6'h00, CMP_EN});
    chk("gate select", 8'h01, {7'h00, T1_GATE_SEL});
    $display("test reset done");
    // Every mode with the input switch set.
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CTRL, 8'(m) | 8'h08);
      idle(8);
      rd(ADDR_CTRL, rv);
      chk("mode", 8'(m) | 8'h08, rv & 8'h3F);
      rdc("port", ADDR_PORT, {2'h0, PIN_IN & ~amask(m)});
      chk("input switch", {6'h00, (m == 1) ? 2'h1 : (m == 2) ? 2'h3 : 2'h0}, {6'h00, INV_SEL});
      chk("enables", (m == 0 || m == 7) ? 8'h00 : 8'h03, {6'h00, CMP_EN});
      if (m != 6) chk("pin out", {2'h0, PORT_DATA}, {2'h0, PIN_OUT});
    end
    $display("test modes done");
    // Output pins and polarity in the pin mode.
    wr(ADDR_DIR, 8'h0F);
    wr(ADDR_CTRL, 8'h06);
    idle(8);
    rdc("ctrl", ADDR_CTRL, 8'h46);
    chk("pin out", 8'h1A, {2'h0, PIN_OUT});
    chk("pin enables", 8'h0F, {2'h0, PIN_OE_N});
    wr(ADDR_CTRL, 8'h36);
    idle(8);
    rdc("ctrl inverted", ADDR_CTRL, 8'hB6);
    chk("pin out inverted", 8'h2A, {2'h0, PIN_OUT});
    $display("test pins done");
    // Change interrupt, persistent mismatch and clearing order.
    wr(ADDR_CTRL, 8'h02);
    idle(8);
    rd(ADDR_CTRL, rv);
    wr(ADDR_PIR, 8'h00);
    wr(ADDR_PIE, 8'h18);
    wr(ADDR_GIC, 8'hC0);
    lvl <= 2'h0;
    idle(8);
    rdc("flags", ADDR_PIR, 8'h08);
    chk("irq", 8'h01, {7'h00, CMP_IRQ});
    chk("wake", 8'h01, {7'h00, WAKE});
    wr(ADDR_PIR, 8'h00);
    idle(4);
    rdc("flags kept", ADDR_PIR, 8'h08);
    rdc("ctrl", ADDR_CTRL, 8'h02);
    wr(ADDR_PIR, 8'h00);
    idle(2);
    rdc("flags cleared", ADDR_PIR, 8'h00);
    chk("irq off", 8'h00, {7'h00, CMP_IRQ});
    // Slow comparator response on the second comparator, ended by a control write.
    slow <= 1'b1;
    lvl <= 2'h2;
    idle(12);
    rdc("second flag", ADDR_PIR, 8'h10);
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_PIR, 8'h00);
    idle(2);
    rdc("flags after write", ADDR_PIR, 8'h00);
    slow <= 1'b0;
    $display("test change interrupt done");
    // Software-set flag and the global and comparator enables.
    wr(ADDR_GIC, 8'h40);
    wr(ADDR_PIR, 8'h08);
    idle(2);
    chk("irq no global", 8'h00, {7'h00, CMP_IRQ});
    chk("wake no global", 8'h01, {7'h00, WAKE});
    rdc("soft flag", ADDR_PIR, 8'h08);
    wr(ADDR_GIC, 8'hC0);
    idle(2);
    chk("irq soft", 8'h01, {7'h00, CMP_IRQ});
    wr(ADDR_PIE, 8'h00);
    idle(2);
    chk("irq masked", 8'h00, {7'h00, CMP_IRQ});
    wr(ADDR_PIR, 8'h00);
    $display("test enables done");
    // Timer gate follows the second comparator, later only on timer ticks.
    chk("gate", 8'h01, {7'h00, T1_GATE});
    wr(ADDR_CFG2, 8'h03);
    lvl <= 2'h0;
    idle(8);
    chk("gate held", 8'h01, {7'h00, T1_GATE});
    T1_TICK <= 1'b1;
    @(posedge REF_CLK);
    T1_TICK <= 1'b0;
    idle(2);
    chk("gate ticked", 8'h00, {7'h00, T1_GATE});
    $display("test timer gate done");
    wrap_up();
  end
endmodule : test_dual_comparator_control_irq
`default_nettype wire
